// file: hdl/mac_unit.v
// Multiply, ALU and work-register file datapath of the processor core
//
// What this block does
// - Signed 17x17 multiply within one cycle
// - Bit 16 zero or copy of bit 15, except top bit of fractional shift operand
// - Product low to ALU same cycle
// - Product high latched at cycle end
// - Multiplicand memory/accumulator/offset; multiplier register or shift
// - Shift code decoded to one-hot multiplier
// - Fractional flag shifts decoded operand once more
// - Multiplier registers load/store; high word transfers
// - Multiplicand written from bus, never read
// - First input: zero, bus, high, low, offset
// - Second input: zero or addressed register
// - Add, sub, load, logic, equality compares
// - Compares never modify work registers
// - Sixteen-bit word, strings via carry chain
// - Thirty-two registers, two sixteen-entry halves
// - File supplies addressed and offset operands
// - Four five-bit pointers, direct addressing
// - Offset partner is address plus sixteen
// - Two-bit field picks the pointer
// - Pointers load, store, load or add constant
`timescale 1ns/100ps
`include "mac_unit_regs.vh"
module mac_unit (
   input wire i_sys_clk,
   input wire i_rst_n,
   // Instruction sequencer controls
   input wire [1:0] i_ptr_sel,
   input wire i_indirect,
   input wire i_use_offset,
   input wire i_swap_operands,
   input wire [`ASEL_W-1:0] i_asel,
   input wire i_bsel_acc,
   input wire [`ALU_OP_W-1:0] i_alu_op,
   input wire [`DST_W-1:0] i_dst,
   input wire i_string_cont,
   input wire i_mul_en,
   input wire i_shift_mode,
   input wire [`MCND_W-1:0] i_mcnd_src,
   input wire i_mcnd_signed,
   input wire i_mplr_signed,
   input wire i_frac_flag,
   input wire [`MOV_W-1:0] i_load_dst,
   input wire [`MOV_W-1:0] i_store_src,
   input wire i_phi_from_acc,
   input wire i_phi_to_acc,
   input wire [`PTR_W-1:0] i_ptr_mode,
   input wire [4:0] i_ptr_const,
   // Data memory / program memory words
   input wire [15:0] i_data_bus,
   // Results
   output reg [15:0] o_store_data,
   output reg o_store_valid,
   output reg [15:0] o_alu_result,
   output reg o_cmp_true,
   output reg o_carry,
   output reg [15:0] o_product_upper_word,
   output reg [15:0] o_multiplier_operand,
   output reg [3:0] o_shift_code
);
   reg [15:0] work_ff [0:`NUM_ACC-1];
   reg [4:0] ptr_ff [0:`NUM_PTR-1];
   reg [15:0] mpr_ff;
   reg [15:0] mcnd_ff;
   reg [15:0] phi_ff;
   reg [3:0] shc_ff;
   reg carry_ff;

   wire [4:0] cur_ptr;
   wire [4:0] prim_addr;
   wire [4:0] ofs_addr;
   wire [4:0] rd_addr;
   wire [4:0] rd_ofs_addr;
   wire [15:0] acc_rd;
   wire [15:0] ofs_rd;
   wire [33:0] product;
   wire [15:0] product_lower_word;
   reg [16:0] mplr_val;
   reg [15:0] mcnd_val;
   reg [15:0] first_adder_input;
   reg [15:0] second_adder_input;
   reg [15:0] nxt_result;
   reg nxt_carry;
   reg nxt_cmp;
   reg [16:0] sum;
   reg [15:0] shift_onehot;
   reg [15:0] nxt_store;
   reg nxt_store_valid;
   reg [4:0] wr_addr;
   reg wr_en;
   reg [15:0] wr_data;
   reg is_cmp;

   assign cur_ptr = ptr_ff[i_ptr_sel];
   // direct form uses all five bits
   assign prim_addr = i_indirect ? {1'b0, cur_ptr[3:0]} : cur_ptr;
   // circular partner, plus sixteen mod 32
   assign ofs_addr = prim_addr + `OFS_STEP;
   // Swap exchanges which of the pair is the addressed operand
   assign rd_addr = (i_swap_operands | i_use_offset) ? ofs_addr : prim_addr;
   assign rd_ofs_addr = (i_swap_operands | i_use_offset) ? prim_addr : ofs_addr;
   assign acc_rd = work_ff[rd_addr];
   assign ofs_rd = work_ff[rd_ofs_addr];

   // one-hot decode of the shift code
   always @* begin
      shift_onehot = 16'h0000;
      shift_onehot[shc_ff] = 1'b1;
   end

   always @* begin
      if (i_shift_mode) begin
         // fractional mode doubles the decoded operand
         if (i_frac_flag) begin
            mplr_val = {shift_onehot, 1'b0};
         end else begin
            mplr_val = {1'b0, shift_onehot};
         end
      end else begin
         mplr_val = {1'b0, mpr_ff};
      end
      case (i_mcnd_src)
         `MCND_ACC: mcnd_val = acc_rd;
         `MCND_OFS: mcnd_val = ofs_rd;
         default: mcnd_val = mcnd_ff;
      endcase
   end

   mul17 u_mul (
      .i_mcnd(mcnd_val),
      .i_mcnd_signed(i_mcnd_signed & ~i_shift_mode),
      .i_mplr(mplr_val),
      .i_mplr_signed(i_mplr_signed & ~i_shift_mode),
      .o_product(product)
   );

   // lower word goes straight to the ALU
   assign product_lower_word = product[15:0];

   // first adder input mux; second input mux
   always @* begin
      case (i_asel)
         `ASEL_BUS: first_adder_input = i_data_bus;
         `ASEL_PHI: first_adder_input = phi_ff;
         `ASEL_PLO: first_adder_input = product_lower_word;
         `ASEL_OFS: first_adder_input = ofs_rd;
         default: first_adder_input = 16'h0000;
      endcase
      second_adder_input = i_bsel_acc ? acc_rd : 16'h0000;
   end

   always @* begin
      sum = 17'h00000;
      nxt_carry = carry_ff;
      nxt_cmp = 1'b0;
      is_cmp = 1'b0;
      case (i_alu_op)
         `ALU_ADD: begin
            // carry links words of a string
            sum = {1'b0, second_adder_input} + {1'b0, first_adder_input} + {16'h0000, (i_string_cont & carry_ff)};
            nxt_result = sum[15:0];
            nxt_carry = sum[16];
         end
         `ALU_SUB: begin
            sum = {1'b0, second_adder_input} + {1'b0, ~first_adder_input}
               + {16'h0000, (i_string_cont ? carry_ff : 1'b1)};
            nxt_result = sum[15:0];
            nxt_carry = sum[16];
         end
         `ALU_LOAD: nxt_result = first_adder_input;
         `ALU_AND: nxt_result = second_adder_input & first_adder_input;
         `ALU_OR: nxt_result = second_adder_input | first_adder_input;
         `ALU_XOR: nxt_result = second_adder_input ^ first_adder_input;
         `ALU_NOT: nxt_result = ~first_adder_input;
         `ALU_CMPEQ: begin
            is_cmp = 1'b1;
            nxt_result = second_adder_input ^ first_adder_input;
            // String compare stays true only while every word matched
            nxt_cmp = (nxt_result == 16'h0000) & (~i_string_cont | o_cmp_true);
         end
         `ALU_CMPNE: begin
            is_cmp = 1'b1;
            nxt_result = second_adder_input ^ first_adder_input;
            nxt_cmp = (nxt_result != 16'h0000) | (i_string_cont & o_cmp_true);
         end
         default: nxt_result = first_adder_input;
      endcase
   end

   // Write-back select and store path
   always @* begin
      wr_en = 1'b0;
      wr_addr = rd_addr;
      wr_data = nxt_result;
      if (!is_cmp) begin
         case (i_dst)
            `DST_ACC: begin
               wr_en = 1'b1;
               wr_addr = rd_addr;
            end
            `DST_OFS: begin
               wr_en = 1'b1;
               wr_addr = rd_ofs_addr;
            end
            default: wr_en = 1'b0;
         endcase
      end
      // high word into a work register
      if (i_phi_to_acc) begin
         wr_en = 1'b1;
         wr_addr = rd_addr;
         wr_data = phi_ff;
      end
      nxt_store_valid = 1'b1;
      case (i_store_src)
         `MOV_MPR: nxt_store = mpr_ff;
         `MOV_PHI: nxt_store = phi_ff;
         `MOV_SHC: nxt_store = {12'h000, shc_ff};
         `MOV_PTR: nxt_store = {11'h000, cur_ptr};
         default: begin
            nxt_store = 16'h0000;
            nxt_store_valid = 1'b0;
         end
      endcase
   end

   // thirty-two word file, one write port
   genvar gi;
   generate
      for (gi = 0; gi < `NUM_ACC; gi = gi + 1) begin : g_work
         always @(posedge i_sys_clk) begin
            if (!i_rst_n) begin
               work_ff[gi] <= `RST_WORD;
            end else if (wr_en && wr_addr == gi) begin
               work_ff[gi] <= wr_data;
            end
         end
      end
      for (gi = 0; gi < `NUM_PTR; gi = gi + 1) begin : g_ptr
         always @(posedge i_sys_clk) begin
            if (!i_rst_n) begin
               ptr_ff[gi] <= `RST_PTR;
            end else if (i_ptr_sel == gi) begin
               if (i_load_dst == `MOV_PTR) begin
                  ptr_ff[gi] <= i_data_bus[4:0];
               end else if (i_ptr_mode == `PTR_LOAD) begin
                  ptr_ff[gi] <= i_ptr_const;
               end else if (i_ptr_mode == `PTR_ADD) begin
                  ptr_ff[gi] <= ptr_ff[gi] + i_ptr_const;
               end
            end
         end
      end
   endgenerate

   always @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         mpr_ff <= `RST_WORD;
         mcnd_ff <= `RST_WORD;
         phi_ff <= `RST_WORD;
         shc_ff <= `RST_SHC;
         carry_ff <= 1'b0;
         o_store_data <= `RST_WORD;
         o_store_valid <= 1'b0;
         o_alu_result <= `RST_WORD;
         o_cmp_true <= 1'b0;
         o_carry <= 1'b0;
         o_product_upper_word <= `RST_WORD;
         o_multiplier_operand <= `RST_WORD;
         o_shift_code <= `RST_SHC;
      end else begin
         // loads from the data bus (memory or program constants)
         if (i_load_dst == `MOV_MPR) begin
            mpr_ff <= i_data_bus;
            o_multiplier_operand <= i_data_bus;
         end
         if (i_load_dst == `MOV_SHC) begin
            shc_ff <= i_data_bus[3:0];
            o_shift_code <= i_data_bus[3:0];
         end
         // multiplicand latch written only from the bus
         if (i_load_dst == `MOV_MCND) begin
            mcnd_ff <= i_data_bus;
         end
         // high word captured at cycle end
         if (i_mul_en) begin
            phi_ff <= product[31:16];
            o_product_upper_word <= product[31:16];
         end else if (i_load_dst == `MOV_PHI) begin
            phi_ff <= i_data_bus;
            o_product_upper_word <= i_data_bus;
         end else if (i_phi_from_acc) begin
            // work register into the high word
            phi_ff <= acc_rd;
            o_product_upper_word <= acc_rd;
         end
         carry_ff <= nxt_carry;
         o_carry <= nxt_carry;
         o_alu_result <= nxt_result;
         if (is_cmp) begin
            o_cmp_true <= nxt_cmp;
         end
         o_store_data <= nxt_store;
         o_store_valid <= nxt_store_valid;
      end
   end
endmodule

// file: hdl/mac_unit_regs.vh
// Constants for the multiply, ALU and work-register datapath
`ifndef MAC_UNIT_REGS_VH
`define MAC_UNIT_REGS_VH

// ALU operation codes
`define ALU_OP_W 4
`define ALU_ADD 4'h0
`define ALU_SUB 4'h1
`define ALU_LOAD 4'h2
`define ALU_AND 4'h3
`define ALU_OR 4'h4
`define ALU_XOR 4'h5
`define ALU_NOT 4'h6
`define ALU_CMPEQ 4'h7
`define ALU_CMPNE 4'h8

// First adder input select
`define ASEL_W 3
`define ASEL_ZERO 3'h0
`define ASEL_BUS 3'h1
`define ASEL_PHI 3'h2
`define ASEL_PLO 3'h3
`define ASEL_OFS 3'h4

// Multiplicand source
`define MCND_W 2
`define MCND_LATCH 2'h0
`define MCND_ACC 2'h1
`define MCND_OFS 2'h2

// Register move targets/sources
`define MOV_W 3
`define MOV_NONE 3'h0
`define MOV_MPR 3'h1
`define MOV_PHI 3'h2
`define MOV_SHC 3'h3
`define MOV_PTR 3'h4
`define MOV_MCND 3'h5

// Pointer update modes
`define PTR_W 2
`define PTR_HOLD 2'h0
`define PTR_LOAD 2'h1
`define PTR_ADD 2'h2

// Accumulator write destination
`define DST_W 2
`define DST_NONE 2'h0
`define DST_ACC 2'h1
`define DST_OFS 2'h2

`define WORD_W 16
`define ADDR_W 5
`define NUM_ACC 32
`define NUM_PTR 4
`define SHC_W 4
`define OFS_STEP 5'h10

// Reset values
`define RST_WORD 16'h0000
`define RST_PTR 5'h00
`define RST_SHC 4'h0

`endif

// file: hdl/mul17.v
// Signed 17x17 multiplier with per-operand sign extension
`timescale 1ns/100ps
module mul17 (
   input wire [15:0] i_mcnd,
   input wire i_mcnd_signed,
   input wire [16:0] i_mplr,
   input wire i_mplr_signed,
   output wire [33:0] o_product
);
   wire signed [16:0] a_ext;
   wire signed [17:0] b_ext;
   wire signed [34:0] prod_full;

   assign a_ext = {(i_mcnd_signed & i_mcnd[15]), i_mcnd};
   // Operand may carry 17 significant bits in fractional shift mode, so widen once more
   // A set bit 16 means a positive 17-bit operand; otherwise bits 17:16 carry the sign
   assign b_ext = i_mplr[16] ? {1'b0, i_mplr} : {{2{i_mplr_signed & i_mplr[15]}}, i_mplr[15:0]};
   assign prod_full = a_ext * b_ext;
   assign o_product = prod_full[33:0];
endmodule

// file: sim/data_mem_model.sv
// Data memory model on the far side of the store and load paths
`timescale 1ns/100ps
module data_mem_model (
   input wire logic i_sys_clk,
   input wire logic i_we,
   input wire logic [3:0] i_addr,
   input wire logic [15:0] i_wdata,
   output logic [15:0] o_rdata
);
   logic [15:0] mem_ff [16];
   // Preset content differs from anything stored, so a lost store shows
   initial foreach (mem_ff[k]) mem_ff[k] = 16'hA5A5 ^ 16'(k);
   always @(posedge i_sys_clk) begin
      if (i_we) begin
         mem_ff[i_addr] <= i_wdata;
      end
   end
   assign o_rdata = mem_ff[i_addr];
endmodule

// file: sim/mac_unit_monitor.sv
// Assertion checker for the multiply, ALU and work-register datapath
`timescale 1ns/100ps
`include "mac_unit_regs.vh"
module mac_unit_monitor (
   input wire i_sys_clk,
   input wire i_rst_n,
   input wire i_mul_en,
   input wire i_shift_mode,
   input wire i_frac_flag,
   input wire i_mcnd_signed,
   input wire i_mplr_signed,
   input wire i_string_cont,
   input wire i_bsel_acc,
   input wire i_phi_from_acc,
   input wire [`MCND_W-1:0] i_mcnd_src,
   input wire [`ASEL_W-1:0] i_asel,
   input wire [`ALU_OP_W-1:0] i_alu_op,
   input wire [`MOV_W-1:0] i_load_dst,
   input wire [`MOV_W-1:0] i_store_src,
   input wire [15:0] i_data_bus,
   input wire o_store_valid,
   input wire o_cmp_true,
   input wire [15:0] o_alu_result,
   input wire [15:0] o_product_upper_word,
   input wire [15:0] o_multiplier_operand,
   input wire [3:0] o_shift_code
);
   // Shadow of the write-only multiplicand, since no port shows it
   reg [15:0] mcnd_ff;
   wire quiet = (i_load_dst == `MOV_NONE) & ~i_phi_from_acc & (i_mcnd_src == `MCND_LATCH) & i_mul_en;
   wire mul_plain = quiet & ~i_shift_mode;
   wire mul_shift = quiet & i_shift_mode;
   wire to_alu = (i_asel == `ASEL_PLO) & ~i_bsel_acc & (i_alu_op == `ALU_ADD) & ~i_string_cont;
   wire signed [33:0] prod = $signed({i_mcnd_signed & mcnd_ff[15], mcnd_ff})
      * $signed({i_mplr_signed & o_multiplier_operand[15], o_multiplier_operand});
   wire [33:0] shifted = {18'h00000, mcnd_ff} << ({1'b0, o_shift_code} + i_frac_flag);
   wire [15:0] prod_lo = prod[15:0];
   wire [15:0] prod_hi = prod[31:16];
   wire [15:0] shift_hi = shifted[31:16];
   always @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         mcnd_ff <= `RST_WORD;
      end else if (i_load_dst == `MOV_MCND) begin
         mcnd_ff <= i_data_bus;
      end
   end
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   mult_low_a: assert property (mul_plain && to_alu |=> o_alu_result == $past(prod_lo))
      else $error("product low word wrong at the ALU");
   product_high_a: assert property (mul_plain |=> o_product_upper_word == $past(prod_hi))
      else $error("product high word not latched");
   shift_decode_a: assert property (mul_shift && !i_frac_flag |=> o_product_upper_word == $past(shift_hi))
      else $error("barrel shift result wrong");
   frac_shift_a: assert property (mul_shift && i_frac_flag |=> o_product_upper_word == $past(shift_hi))
      else $error("fractional shift result wrong");
   mreg_load_a: assert property (i_load_dst == `MOV_MPR |=> o_multiplier_operand == $past(i_data_bus))
      else $error("multiplier register load lost");
   store_pulse_a: assert property (i_store_src != `MOV_NONE |=> o_store_valid)
      else $error("store pulse missing");
   store_idle_a: assert property (i_store_src == `MOV_NONE |=> !o_store_valid)
      else $error("spurious store pulse");
   invert_bus_a: assert property (i_asel == `ASEL_BUS && i_alu_op == `ALU_NOT |=> o_alu_result == ~$past(i_data_bus))
      else $error("inverse of bus word wrong");
   zero_sum_a: assert property (i_asel == `ASEL_ZERO && !i_bsel_acc && !i_string_cont && i_alu_op == `ALU_ADD
      |=> o_alu_result == 16'h0000)
      else $error("zero inputs gave nonzero sum");
   cmp_hold_a: assert property (i_alu_op < `ALU_CMPEQ |=> $stable(o_cmp_true))
      else $error("compare flag moved without a compare");
endmodule
bind mac_unit mac_unit_monitor mac_unit_monitor_inst (.*);

// file: sim/tb_top.sv
// Self-checking bench for the multiply, ALU and work-register datapath
`timescale 1ns/100ps
`include "mac_unit_regs.vh"
module tb_top;
   logic i_sys_clk, i_rst_n, i_indirect, i_use_offset, i_swap_operands, i_bsel_acc, i_string_cont, i_mul_en;
   logic i_shift_mode, i_mcnd_signed, i_mplr_signed, i_frac_flag, i_phi_from_acc, i_phi_to_acc, use_mem;
   logic [1:0] i_ptr_sel, i_dst, i_mcnd_src, i_ptr_mode;
   logic [2:0] i_asel, i_load_dst, i_store_src;
   logic [3:0] i_alu_op, mem_addr, o_shift_code;
   logic [4:0] i_ptr_const;
   logic [15:0] i_data_bus, bus_drv, mem_rd, o_store_data, o_alu_result, o_product_upper_word;
   logic [15:0] o_multiplier_operand, a, b, c, e;
   logic o_store_valid, o_cmp_true, o_carry;
   logic signed [33:0] p;
   logic [33:0] q;
   int num_errors = 0, checks = 0, seed = 32'h36f1, i;
   typedef struct {int kind; logic [15:0] val;} note_t;
   note_t notes[$];
   note_t n;
   assign i_data_bus = use_mem ? mem_rd : bus_drv;
   mac_unit mac_unit_inst (.*);
   data_mem_model data_mem_model_inst (.i_sys_clk(i_sys_clk), .i_we(o_store_valid), .i_addr(mem_addr),
      .i_wdata(o_store_data), .o_rdata(mem_rd));
   initial begin
      i_sys_clk = 1'b0;
      forever #20 i_sys_clk = ~i_sys_clk;
   end
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic cmp_word(input string name, input logic [15:0] x, input logic [15:0] g);
      checks++;
      if (g !== x) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, x, g);
      end
   endtask
   task automatic cmp_bit(input string name, input logic x, input logic g);
      cmp_word(name, {15'h0000, x}, {15'h0000, g});
   endtask
   task automatic clr;
      {i_indirect, i_use_offset, i_swap_operands, i_bsel_acc, i_string_cont, i_mul_en, i_shift_mode} = 7'h00;
      {i_mcnd_signed, i_mplr_signed, i_frac_flag, i_phi_from_acc, i_phi_to_acc, use_mem} = 6'h00;
      {i_ptr_sel, i_dst, i_mcnd_src, i_ptr_mode, i_asel, i_load_dst, i_store_src, i_alu_op, i_ptr_const} = 26'h0000000;
   endtask
   task automatic cyc;
      @(negedge i_sys_clk);
      clr;
   endtask
   task automatic exp(input int k, input logic [15:0] v);
      notes.push_back('{k, v});
   endtask
   task automatic ptr(input logic [1:0] ps, input logic [1:0] m, input logic [4:0] k);
      cyc;
      i_ptr_sel = ps;
      i_ptr_mode = m;
      i_ptr_const = k;
   endtask
   task automatic wr(input logic [1:0] ps, input logic [1:0] d, input logic [15:0] v);
      cyc;
      i_ptr_sel = ps;
      i_asel = `ASEL_BUS;
      i_alu_op = `ALU_OR;
      i_dst = d;
      bus_drv = v;
      exp(0, v);
   endtask
   task automatic rd(input logic [1:0] ps, input logic ind, input logic ofs, input logic [15:0] v);
      cyc;
      i_ptr_sel = ps;
      i_indirect = ind;
      i_use_offset = ofs;
      i_bsel_acc = 1'b1;
      i_alu_op = `ALU_OR;
      exp(0, v);
   endtask
   // Each note belongs to the edge right after it was queued
   always @(posedge i_sys_clk) begin
      #1;
      while (notes.size() > 0) begin
         n = notes.pop_front();
         case (n.kind)
            0: cmp_word("alu result", n.val, o_alu_result);
            1: begin
               cmp_bit("store pulse", 1'b1, o_store_valid);
               cmp_word("store data", n.val, o_store_data);
            end
            2: cmp_word("product upper word", n.val, o_product_upper_word);
            3: cmp_word("multiplier operand", n.val, o_multiplier_operand);
            4: cmp_word("shift code", n.val, {12'h000, o_shift_code});
            6: cmp_bit("carry", n.val[0], o_carry);
            default: cmp_bit("compare flag", n.val[0], o_cmp_true);
         endcase
      end
   end
   initial begin
      repeat (3000) @(posedge i_sys_clk);
      num_errors++;
      $display("watchdog expired");
      wrap_up;
   end
   initial begin
      clr;
      bus_drv = 16'h0000;
      mem_addr = 4'h5;
      i_rst_n = 1'b0;
      repeat (5) @(negedge i_sys_clk);
      i_rst_n = 1'b1;
      for (i = 0; i < 8; i++) begin
         a = (i == 0) ? 16'h8000 : 16'($random(seed));
         b = (i == 0) ? 16'hFFFF : 16'($random(seed));
         cyc;
         i_load_dst = `MOV_MPR;
         bus_drv = a;
         exp(3, a);
         cyc;
         i_load_dst = `MOV_MCND;
         bus_drv = b;
         cyc;
         i_mul_en = 1'b1;
         i_mcnd_signed = i[0];
         i_mplr_signed = i[1];
         i_asel = `ASEL_PLO;
         p = $signed({i[0] & b[15], b}) * $signed({i[1] & a[15], a});
         exp(0, p[15:0]);
         exp(2, p[31:16]);
      end
      $display("multiply test done");
      for (i = 0; i < 32; i++) begin
         cyc;
         i_load_dst = `MOV_SHC;
         bus_drv = 16'hFFF0 | 16'(i % 16);
         exp(4, 16'(i % 16));
         cyc;
         i_mul_en = 1'b1;
         i_shift_mode = 1'b1;
         i_frac_flag = i[4];
         i_asel = `ASEL_PLO;
         q = {18'h00000, b} << (i % 16 + i[4]);
         exp(2, q[31:16]);
         exp(0, q[15:0]);
      end
      $display("shift test done");
      ptr(2'h1, `PTR_LOAD, 5'h1E);
      ptr(2'h1, `PTR_ADD, 5'h03);
      cyc;
      i_ptr_sel = 2'h1;
      i_store_src = `MOV_PTR;
      exp(1, 16'h0001);
      wr(2'h1, `DST_ACC, a);
      wr(2'h1, `DST_OFS, b);
      rd(2'h1, 1'b0, 1'b0, a);
      rd(2'h1, 1'b0, 1'b1, b);
      ptr(2'h2, `PTR_LOAD, 5'h11);
      rd(2'h2, 1'b1, 1'b0, a);
      rd(2'h2, 1'b0, 1'b0, b);
      rd(2'h2, 1'b0, 1'b1, a);
      cyc;
      i_ptr_sel = 2'h1;
      i_asel = `ASEL_OFS;
      i_bsel_acc = 1'b1;
      exp(0, a + b);
      for (i = 0; i < 9; i++) begin
         c = (i == 1 || i > 6) ? a : 16'($random(seed));
         cyc;
         i_ptr_sel = 2'h1;
         i_asel = `ASEL_BUS;
         i_bsel_acc = (i != 2);
         i_alu_op = 4'(i);
         i_dst = (i > 6) ? `DST_ACC : `DST_NONE;
         bus_drv = c;
         case (i)
            0: e = c + a;
            1: e = 16'h0000;
            2: e = c;
            3: e = c & a;
            4: e = c | a;
            5: e = c ^ a;
            6: e = ~c;
            default: e = {15'h0000, i == 7};
         endcase
         exp((i > 6) ? 5 : 0, e);
         if (i < 2) exp(6, {15'h0000, (i == 1) || (17'(c) + 17'(a) > 17'h0FFFF)});
      end
      rd(2'h1, 1'b0, 1'b0, a);
      cyc;
      i_ptr_sel = 2'h1;
      i_phi_from_acc = 1'b1;
      exp(2, a);
      cyc;
      i_store_src = `MOV_PHI;
      exp(1, a);
      cyc;
      cyc;
      use_mem = 1'b1;
      i_load_dst = `MOV_MPR;
      exp(3, a);
      cyc;
      i_ptr_sel = 2'h2;
      i_phi_to_acc = 1'b1;
      rd(2'h2, 1'b0, 1'b0, a);
      cyc;
      cyc;
      $display("register file test done");
      wrap_up;
   end
endmodule
